// ===== design/strap_pkg.sv
// Summary of operation
// - at reset release receive-data pins three, two and one are captured as station address bits zero, one and two.
// - at reset release the receive-data bit-zero pin is captured as the duplex setting.
// - at reset release the receive-data-valid pin is captured as the mode-select most significant bit.
// - at reset release the receive-clock pin is captured as the broadcast address disable setting.
// - at reset release the receive-error pin is captured as the isolate-from-MAC setting.
// - at reset release the interrupt pin is captured as the active-low pin-chain test select.
// - after capture, unless isolated, the shared pins are driven as receive data, data valid, receive clock and receive error.
// - the interrupt pin is a programmable open-drain active-low event output released to its pull-up.
// - the management clock comes from the master and the open-drain data line is sampled on its rising edges.
// - the device runs from its single timing reference on the clock input.
package strap_pkg;
   // clock figures
   localparam int CLK_HZ = 40_000_000;
   localparam int REF_CRYSTAL_HZ = 25_000_000;

   // strap vector layout
   localparam int STRAP_W = 8;
   localparam int S_ADDR0 = 0;
   localparam int S_ADDR1 = 1;
   localparam int S_ADDR2 = 2;
   localparam int S_DUPLEX = 3;
   localparam int S_MODE_MSB = 4;
   localparam int S_BCAST_OFF = 5;
   localparam int S_ISOLATE = 6;
   localparam int S_TEST_N = 7;
   localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;

   // register byte addresses
   localparam logic [7:0] A_STRAP = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h04;
   localparam logic [7:0] A_INT_STAT = 8'h08;
   localparam logic [7:0] A_INT_MASK = 8'h0C;

   // control fields
   localparam int CTRL_W = 3;
   localparam int C_ISOLATE = 0;
   localparam int C_BCAST_OFF = 1;
   localparam int C_EVT_EN = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

   // interrupt fields
   localparam int IRQ_W = 4;
   localparam int I_CAPTURED = 0;
   localparam int CORE_EVT_W = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;

   // start-up phase
   typedef enum logic [0:0] {
      PH_HOLD = 1'b0,
      PH_RUN = 1'b1
   } phase_t;
endpackage : strap_pkg

// ===== design/strap_latch.sv
`timescale 1ns/100ps
// holds a vector sampled once on a capture strobe
module strap_latch #(
   parameter int W = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic capture_in,
   input wire logic [W-1:0] pins_in,
   output logic [W-1:0] value_out
);
   typedef struct packed {
      logic [W-1:0] value;
   } latch_t;

   latch_t st_reg;
   latch_t st_next;

   // take the pin levels only on the strobe
   always_comb begin
      st_next = st_reg;
      if (capture_in) begin
         st_next.value = pins_in;
      end
   end

   // synchronous reset to a constant
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign value_out = st_reg.value;
endmodule : strap_latch

// ===== design/strap_pin_ctrl.sv
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
// strap capture, shared pin roles and a small AHB-Lite register file
module strap_pin_ctrl (
   input wire logic clk_in,
   input wire logic rst_n_in,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // shared receive pins
   input wire logic [3:0] rxd_in,
   output logic [3:0] rxd_out,
   output logic [3:0] rxd_oe_n_out,
   input wire logic rxdv_in,
   output logic rxdv_out,
   output logic rxdv_oe_n_out,
   input wire logic rxc_in,
   output logic rxc_out,
   output logic rxc_oe_n_out,
   input wire logic rxer_in,
   output logic rxer_out,
   output logic rxer_oe_n_out,
   // open-drain event pin
   input wire logic event_n_in,
   output logic event_out_n,
   output logic event_oe_n_out,
   // management pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n_out,
   // transmit pins from the mac
   input wire logic txen_in,
   input wire logic [3:0] txd_in,
   // core side
   input wire logic [3:0] core_rxd_in,
   input wire logic core_rxdv_in,
   input wire logic core_rxc_in,
   input wire logic core_rxer_in,
   input wire logic [strap_pkg::CORE_EVT_W-1:0] core_event_in,
   input wire logic mgmt_drive_in,
   input wire logic mgmt_bit_in,
   output logic mgmt_bit_out,
   output logic mgmt_valid_out,
   output logic core_txen_out,
   output logic [3:0] core_txd_out,
   output logic [2:0] management_station_address_out,
   output logic duplex_out,
   output logic mode_select_strap_msb_out,
   output logic broadcast_disable_out,
   output logic isolate_out,
   output logic pin_chain_test_out,
   output logic irq_out
);
   typedef struct packed {
      strap_pkg::phase_t phase;
      logic [3:0] rxd;
      logic rxdv;
      logic rxc;
      logic rxer;
      logic mii_oe_n;
      logic evt_oe_n;
      logic mdc_prev;
      logic mgmt_bit;
      logic mgmt_valid;
      logic mdio_oe_n;
      logic txen;
      logic [3:0] txd;
      logic [strap_pkg::CTRL_W-1:0] ctrl;
      logic [strap_pkg::IRQ_W-1:0] int_stat;
      logic [strap_pkg::IRQ_W-1:0] int_mask;
      logic irq;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } st_t;

   st_t st_reg;
   st_t st_next;
   logic capture;
   logic [strap_pkg::STRAP_W-1:0] strap_pins;
   logic [strap_pkg::STRAP_W-1:0] strap_val;
   logic addr_phase;
   logic [strap_pkg::IRQ_W-1:0] evt_set;
   logic [strap_pkg::IRQ_W-1:0] w1c;

   // sample at the first edge after reset release, pins still undriven
   assign capture = (st_reg.phase == strap_pkg::PH_HOLD);
   assign strap_pins = {event_n_in, rxer_in, rxc_in, rxdv_in, rxd_in[0], rxd_in[1], rxd_in[2], rxd_in[3]};

   // captured straps
   strap_latch #(
      .W(strap_pkg::STRAP_W)
   ) u_straps (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .capture_in(capture),
      .pins_in(strap_pins),
      .value_out(strap_val)
   );

   assign addr_phase = hsel && htrans[1] && hready;
   assign evt_set = {core_event_in, capture};
   assign w1c = (st_reg.wr_pend && st_reg.wr_addr == strap_pkg::A_INT_STAT) ? hwdata[strap_pkg::IRQ_W-1:0] :
      strap_pkg::IRQ_RESET;

   // next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.mgmt_valid = 1'b0;
      // leave hold after one capture edge, preload control from the pins
      if (capture) begin
         st_next.phase = strap_pkg::PH_RUN;
         st_next.ctrl[strap_pkg::C_ISOLATE] = rxer_in;
         st_next.ctrl[strap_pkg::C_BCAST_OFF] = rxc_in;
      end
      // receive pins driven from the core after capture unless isolated
      if (st_reg.phase == strap_pkg::PH_RUN) begin
         st_next.rxd = core_rxd_in;
         st_next.rxdv = core_rxdv_in;
         st_next.rxc = core_rxc_in;
         st_next.rxer = core_rxer_in;
         st_next.mii_oe_n = st_reg.ctrl[strap_pkg::C_ISOLATE];
      end
      // transmit inputs registered toward the core
      st_next.txen = txen_in;
      st_next.txd = txd_in;
      // management bits sampled on rising mdc
      st_next.mdc_prev = mdc_in;
      if (mdc_in && !st_reg.mdc_prev) begin
         st_next.mgmt_bit = mdio_in;
         st_next.mgmt_valid = 1'b1;
      end
      st_next.mdio_oe_n = !(mgmt_drive_in && !mgmt_bit_in && st_reg.phase == strap_pkg::PH_RUN);
      // sticky events, set wins over a write-one clear
      st_next.int_stat = (st_reg.int_stat & ~w1c) | evt_set;
      st_next.irq = |(st_next.int_stat & st_reg.int_mask);
      // pull the event pin low while enabled and an unmasked event is pending
      st_next.evt_oe_n = !(st_next.irq && st_reg.ctrl[strap_pkg::C_EVT_EN] &&
         st_reg.phase == strap_pkg::PH_RUN);
      // write data phase
      if (st_reg.wr_pend) begin
         if (st_reg.wr_addr == strap_pkg::A_CTRL) begin
            st_next.ctrl = hwdata[strap_pkg::CTRL_W-1:0];
         end else if (st_reg.wr_addr == strap_pkg::A_INT_MASK) begin
            st_next.int_mask = hwdata[strap_pkg::IRQ_W-1:0];
         end
      end
      // address phase: latch writes, prepare read data
      st_next.wr_pend = addr_phase && hwrite;
      st_next.wr_addr = haddr[7:0];
      if (addr_phase && !hwrite) begin
         if (haddr[7:0] == strap_pkg::A_STRAP) begin
            st_next.rdata = {24'h00_0000, strap_val};
         end else if (haddr[7:0] == strap_pkg::A_CTRL) begin
            st_next.rdata = {29'h0000_0000, st_reg.ctrl};
         end else if (haddr[7:0] == strap_pkg::A_INT_STAT) begin
            st_next.rdata = {28'h000_0000, st_reg.int_stat};
         end else if (haddr[7:0] == strap_pkg::A_INT_MASK) begin
            st_next.rdata = {28'h000_0000, st_reg.int_mask};
         end else begin
            st_next.rdata = strap_pkg::ZERO_WORD;
         end
      end
   end

   // state register, pins released during reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
         st_reg.phase <= strap_pkg::PH_HOLD;
         st_reg.mii_oe_n <= 1'b1;
         st_reg.evt_oe_n <= 1'b1;
         st_reg.mdio_oe_n <= 1'b1;
         st_reg.ctrl <= strap_pkg::CTRL_RESET;
         st_reg.int_stat <= strap_pkg::IRQ_RESET;
         st_reg.int_mask <= strap_pkg::IRQ_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register or tied to constants
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_reg.rdata;
   assign rxd_out = st_reg.rxd;
   assign rxd_oe_n_out = {4{st_reg.mii_oe_n}};
   assign rxdv_out = st_reg.rxdv;
   assign rxdv_oe_n_out = st_reg.mii_oe_n;
   assign rxc_out = st_reg.rxc;
   assign rxc_oe_n_out = st_reg.mii_oe_n;
   assign rxer_out = st_reg.rxer;
   assign rxer_oe_n_out = st_reg.mii_oe_n;
   assign event_out_n = 1'b0;
   assign event_oe_n_out = st_reg.evt_oe_n;
   assign mdio_out = 1'b0;
   assign mdio_oe_n_out = st_reg.mdio_oe_n;
   assign mgmt_bit_out = st_reg.mgmt_bit;
   assign mgmt_valid_out = st_reg.mgmt_valid;
   assign core_txen_out = st_reg.txen;
   assign core_txd_out = st_reg.txd;
   // decoded strap values, control bits and the interrupt, the timing reference being clk_in
   assign management_station_address_out = {strap_val[strap_pkg::S_ADDR2], strap_val[strap_pkg::S_ADDR1],
      strap_val[strap_pkg::S_ADDR0]};
   assign duplex_out = strap_val[strap_pkg::S_DUPLEX];
   assign mode_select_strap_msb_out = strap_val[strap_pkg::S_MODE_MSB];
   assign broadcast_disable_out = st_reg.ctrl[strap_pkg::C_BCAST_OFF];
   assign isolate_out = st_reg.ctrl[strap_pkg::C_ISOLATE];
   assign pin_chain_test_out = !strap_val[strap_pkg::S_TEST_N];
   assign irq_out = st_reg.irq;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_addr_capture;
      (rst_n_in && capture) |=>
         management_station_address_out == {$past(rxd_in[1]), $past(rxd_in[2]), $past(rxd_in[3])};
   endproperty
   a_addr_capture: assert property (p_addr_capture) else $error("station address not captured");

   property p_duplex_capture;
      (rst_n_in && capture) |=> duplex_out == $past(rxd_in[0]);
   endproperty
   a_duplex_capture: assert property (p_duplex_capture) else $error("duplex not captured");

   property p_mode_capture;
      (rst_n_in && capture) |=> mode_select_strap_msb_out == $past(rxdv_in);
   endproperty
   a_mode_capture: assert property (p_mode_capture) else $error("mode bit not captured");

   property p_bcast_capture;
      (rst_n_in && capture) |=> broadcast_disable_out == $past(rxc_in);
   endproperty
   a_bcast_capture: assert property (p_bcast_capture) else $error("broadcast disable not captured");

   property p_iso_capture;
      (rst_n_in && capture) |=> isolate_out == $past(rxer_in);
   endproperty
   a_iso_capture: assert property (p_iso_capture) else $error("isolate not captured");

   property p_test_capture;
      (rst_n_in && capture) |=> pin_chain_test_out == !$past(event_n_in);
   endproperty
   a_test_capture: assert property (p_test_capture) else $error("test select not captured");

   property p_drive_after;
      (st_reg.phase == strap_pkg::PH_RUN && !isolate_out) ##1 !isolate_out |-> !rxdv_oe_n_out;
   endproperty
   a_drive_after: assert property (p_drive_after) else $error("receive pins not driven");

   property p_event_pin;
      (irq_out && st_reg.ctrl[strap_pkg::C_EVT_EN]) |-> ##[0:1] !event_oe_n_out || !irq_out;
   endproperty
   a_event_pin: assert property (p_event_pin) else $error("event pin not pulled low");

   property p_mdc_sample;
      (mdc_in && !st_reg.mdc_prev) |=> mgmt_valid_out && mgmt_bit_out == $past(mdio_in);
   endproperty
   a_mdc_sample: assert property (p_mdc_sample) else $error("management bit missed");

   property p_hold_undriven;
      capture |-> rxdv_oe_n_out && rxc_oe_n_out && rxer_oe_n_out && event_oe_n_out && (&rxd_oe_n_out);
   endproperty
   a_hold_undriven: assert property (p_hold_undriven) else $error("strap pin driven during capture");
endmodule : strap_pin_ctrl

// ===== test/mii_far_side.sv
`timescale 1ns/100ps
// mac and management master facing the device
module mii_far_side (
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic slow_in,
   input wire logic master_low_in,
   input wire logic [4:0] tx_word_in,
   output logic mdc_out,
   output logic mdio_drive_n_out,
   output logic txen_out,
   output logic [3:0] txd_out
);
   logic [1:0] cnt;

   // idle state before the first edge
   initial begin
      {mdc_out, txen_out, txd_out, cnt} = '0;
      mdio_drive_n_out = 1'h1;
   end

   // clock stands low outside frames; half period of one or three cycles
   always @(posedge clk_in) begin
      if (!run_in) begin
         mdc_out <= 1'h0;
         cnt <= 2'h0;
      end else if (cnt == (slow_in ? 2'h2 : 2'h0)) begin
         mdc_out <= ~mdc_out;
         cnt <= 2'h0;
      end else begin
         cnt <= cnt + 2'h1;
      end
      mdio_drive_n_out <= ~master_low_in;
      txen_out <= tx_word_in[4];
      txd_out <= tx_word_in[4] ? tx_word_in[3:0] : ~txd_out;
   end
endmodule : mii_far_side

// ===== test/test_strap_pin_ctrl.sv
`timescale 1ns/100ps
module test_strap_pin_ctrl;
   logic clk_in, rst_n_in, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, core_event_in, management_station_address_out;
   logic [3:0] rxd_in, rxd_out, rxd_oe_n_out, rxd_pull, core_rxd_in, txd_in, core_txd_out, misc_pull;
   logic rxdv_in, rxdv_out, rxdv_oe_n_out, rxc_in, rxc_out, rxc_oe_n_out, rxer_in, rxer_out, rxer_oe_n_out;
   logic event_n_in, event_out_n, event_oe_n_out, mdc_in, mdio_in, mdio_out, mdio_oe_n_out, mdio_drive_n;
   logic txen_in, core_rxdv_in, core_rxc_in, core_rxer_in, mgmt_drive_in, mgmt_bit_in, mgmt_bit_out;
   logic mgmt_valid_out, core_txen_out, duplex_out, mode_select_strap_msb_out, broadcast_disable_out;
   logic isolate_out, pin_chain_test_out, irq_out, run, slow, master_low;
   logic [4:0] tx_word;
   int n_errors = 0;
   int tests_run = 0;

   // pin levels: device where enabled, board pulls otherwise
   assign hready = hreadyout;
   assign rxd_in = (rxd_oe_n_out & rxd_pull) | (~rxd_oe_n_out & rxd_out);
   assign rxdv_in = rxdv_oe_n_out ? misc_pull[0] : rxdv_out;
   assign rxc_in = rxc_oe_n_out ? misc_pull[1] : rxc_out;
   assign rxer_in = rxer_oe_n_out ? misc_pull[2] : rxer_out;
   assign event_n_in = event_oe_n_out ? misc_pull[3] : event_out_n;
   assign mdio_in = (mdio_oe_n_out | mdio_out) & mdio_drive_n;

   strap_pin_ctrl strap_pin_ctrl_i (.clk_in, .rst_n_in, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .rxd_in, .rxd_out, .rxd_oe_n_out, .rxdv_in, .rxdv_out, .rxdv_oe_n_out, .rxc_in,
      .rxc_out, .rxc_oe_n_out, .rxer_in, .rxer_out, .rxer_oe_n_out, .event_n_in, .event_out_n, .event_oe_n_out,
      .mdc_in, .mdio_in, .mdio_out, .mdio_oe_n_out, .txen_in, .txd_in, .core_rxd_in, .core_rxdv_in, .core_rxc_in,
      .core_rxer_in, .core_event_in, .mgmt_drive_in, .mgmt_bit_in, .mgmt_bit_out, .mgmt_valid_out, .core_txen_out,
      .core_txd_out, .management_station_address_out, .duplex_out, .mode_select_strap_msb_out,
      .broadcast_disable_out, .isolate_out, .pin_chain_test_out, .irq_out);
   mii_far_side mii_far_side_i (.clk_in, .run_in(run), .slow_in(slow), .master_low_in(master_low),
      .tx_word_in(tx_word), .mdc_out(mdc_in), .mdio_drive_n_out(mdio_drive_n), .txen_out(txen_in), .txd_out(txd_in));

   // 40 MHz reference
   initial begin
      clk_in = 1'h0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic end_sim;
      if (n_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   // waits for hready at a rising edge, bounded
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (hreadyout !== 1'h1 && n < 50);
      if (hreadyout !== 1'h1) begin
         n_errors++;
         end_sim();
      end
   endtask : wait_ready

   // one single-word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_in);
      hsel <= 1'h1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : ahb

   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      ahb(1'h1, a, v, d);
   endtask : reg_write

   task automatic reg_check(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      ahb(1'h0, a, 32'h0000_0000, d);
      check(what, exp, d);
   endtask : reg_check

   // reset with given pulls, then the captured settings and pin roles
   task automatic capture_case(input logic [7:0] s);
      @(posedge clk_in);
      rst_n_in <= 1'h0;
      rxd_pull <= {s[0], s[1], s[2], s[3]};
      misc_pull <= s[7:4];
      repeat (16) @(posedge clk_in);
      #1;
      check("pins in reset", 32'h0000_01FF, 32'({rxd_oe_n_out, rxdv_oe_n_out, rxc_oe_n_out, rxer_oe_n_out,
         event_oe_n_out, mdio_oe_n_out}));
      @(posedge clk_in);
      rst_n_in <= 1'h1;
      repeat (3) @(posedge clk_in);
      rxd_pull <= ~rxd_pull;
      misc_pull <= {1'h1, ~misc_pull[2:0]};
      #1;
      check("station address", 32'(s[2:0]), 32'(management_station_address_out));
      check("duplex", 32'(s[3]), 32'(duplex_out));
      check("mode msb", 32'(s[4]), 32'(mode_select_strap_msb_out));
      check("broadcast off", 32'(s[5]), 32'(broadcast_disable_out));
      check("isolate", 32'(s[6]), 32'(isolate_out));
      check("test select", 32'(!s[7]), 32'(pin_chain_test_out));
      check("rxd enables", 32'({4{s[6]}}), 32'(rxd_oe_n_out));
      reg_check("strap word", strap_pkg::A_STRAP, 32'(s));
      reg_write(strap_pkg::A_STRAP, 32'hFFFF_FFFF);
      reg_check("strap word kept", strap_pkg::A_STRAP, 32'(s));
      reg_check("capture flag", strap_pkg::A_INT_STAT, 32'h0000_0001);
   endtask : capture_case

   // core receive values reach the shared pins one cycle later
   task automatic rx_case;
      logic [6:0] v;
      for (int k = 0; k < 2; k++) begin
         v = k ? 7'h5A : 7'h25;
         @(posedge clk_in);
         {core_rxd_in, core_rxdv_in, core_rxc_in, core_rxer_in} <= v;
         repeat (2) @(posedge clk_in);
         #1;
         check("receive pins", 32'(v), 32'({rxd_in, rxdv_in, rxc_in, rxer_in}));
      end
   endtask : rx_case

   // event raised, masked, unmasked and cleared on the open-drain pin
   task automatic irq_case;
      reg_write(8'h10, 32'hFFFF_FFFF);
      reg_check("unmapped", 8'h10, 32'h0000_0000);
      reg_write(strap_pkg::A_CTRL, 32'h0000_0004);
      reg_write(strap_pkg::A_INT_STAT, 32'h0000_0001);
      @(posedge clk_in);
      core_event_in <= 3'h1;
      @(posedge clk_in);
      core_event_in <= 3'h0;
      reg_check("status set", strap_pkg::A_INT_STAT, 32'h0000_0002);
      #1;
      check("masked event", 32'h0000_0001, 32'({irq_out, event_n_in}));
      reg_write(strap_pkg::A_INT_MASK, 32'h0000_0002);
      repeat (2) @(posedge clk_in);
      #1;
      check("event pin low", 32'h0000_0002, 32'({irq_out, event_n_in}));
      reg_write(strap_pkg::A_INT_STAT, 32'h0000_0002);
      repeat (2) @(posedge clk_in);
      #1;
      check("event pin released", 32'h0000_0001, 32'({irq_out, event_n_in}));
   endtask : irq_case

   // management line: core drives low, core releases, master drives low
   task automatic mgmt_case;
      logic [3:0] t;
      for (int k = 0; k < 3; k++) begin
         t = k == 0 ? 4'h9 : (k == 1 ? 4'hC : 4'h3);
         @(posedge clk_in);
         {mgmt_drive_in, mgmt_bit_in, master_low, slow} <= t;
         run <= 1'h1;
         repeat (3) @(posedge clk_in);
         #1;
         for (int n = 0; n < 20 && mgmt_valid_out !== 1'h1; n++) begin
            @(posedge clk_in);
            #1;
         end
         check("mgmt bit", 32'({1'h1, (t[3] ? t[2] : 1'h1) & ~t[1]}), 32'({mgmt_valid_out, mgmt_bit_out}));
         @(posedge clk_in);
         #1;
         check("mgmt valid pulse", 32'h0000_0000, 32'(mgmt_valid_out));
      end
      @(posedge clk_in);
      run <= 1'h0;
      master_low <= 1'h0; // master releases the data line after its frames
   endtask : mgmt_case

   // transmit inputs from the mac
   task automatic tx_case;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_in);
         tx_word <= k ? 5'h15 : 5'h1A;
         repeat (3) @(posedge clk_in);
         #1;
         check("transmit", k ? 32'h0000_0015 : 32'h0000_001A, 32'({core_txen_out, core_txd_out}));
      end
   endtask : tx_case

   // main sequence
   initial begin
      {rst_n_in, hsel, htrans, hwrite, haddr, hwdata, rxd_pull, core_rxd_in, core_rxdv_in, core_rxc_in} = '0;
      {core_rxer_in, core_event_in, mgmt_drive_in, mgmt_bit_in, run, slow, master_low, tx_word} = '0;
      hsize = 3'h2;
      misc_pull = 4'h8;
      capture_case(8'h55);
      capture_case(8'hAA);
      rx_case();
      irq_case();
      mgmt_case();
      tx_case();
      end_sim();
   end

   // watchdog
   initial begin
      #100000;
      n_errors++;
      end_sim();
   end
endmodule : test_strap_pin_ctrl
